// *** fabric_model.sv ***
// fabric side: sector clock source and two-way data pin
`timescale 1ns/1ps
`default_nettype none
module fabric_model (
  // clock
  input wire logic core_clk_i,
  input wire logic run_i,
  output logic sector_clk_o,
  // data pin
  input wire logic [3:0] pin_out_i,
  input wire logic pin_oe_i,
  input wire logic [3:0] drive_i,
  output logic [3:0] pin_in_o
);
  int cnt = 0;
  initial sector_clk_o = 1'b0;
  // six core cycles a phase, parked low between bursts
  always @(posedge core_clk_i) begin
    cnt = (cnt + 1) % 6;
    if (!run_i) begin
      sector_clk_o <= 1'b0;
    end else if (cnt == 0) begin
      sector_clk_o <= !sector_clk_o;
    end
  end
  assign pin_in_o = pin_oe_i ? pin_out_i : drive_i;
endmodule : fabric_model
`default_nettype wire

// *** front_latch.sv ***
// transparent latch modelled on the core clock: passes at load 1, holds at 0
`timescale 1ns/1ps
`default_nettype none
module front_latch #(
  parameter int unsigned WIDTH = 1
) (
  // clock and reset
  input wire logic core_clk_i,
  input wire logic reset_n_i,
  // latch
  input wire logic load_i,
  input wire logic [WIDTH-1:0] d_i,
  output logic [WIDTH-1:0] q_o
);
  logic [WIDTH-1:0] held_q;
  logic [WIDTH-1:0] held_d;

  always_comb begin
    held_d = held_q;
    if (load_i) begin
      held_d = d_i;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (!reset_n_i) begin
      held_q <= '0;
    end else begin
      held_q <= held_d;
    end
  end

  assign q_o = load_i ? d_i : held_q;
endmodule : front_latch
`default_nettype wire

// *** ram_blk_pkg.sv ***
// constants and types shared by the 32x4 ram block design
// Overview of operation
// - holds 32 words of 4 bits, 5-bit write address, 4-bit data in and out
// - dual-port use adds a separate 5-bit read address port
// - single-port use reads and writes at write address over one two-way data port
// - rightmost placement ties read address off and forces single-port use
// - reads are combinational and independent of the write path
// - front latches pass address, write enable and data at load 1, hold at 0
// - a nibble follows latched data only when addressed, load 1 and strobe 0
// - in synchronous mode opposite-phase latches form an edge-triggered write register
// - one mode choice drives both load selectors: clock, or constant 1
// - synchronous mode clocks from the sector-column clock left and above
// - any write to the clear byte during configuration zeroes every word
`default_nettype none
package ram_blk_pkg;
  localparam int unsigned ADDR_W = 5;
  localparam int unsigned DATA_W = 4;
  localparam int unsigned WORDS = 32;
  localparam int unsigned REG_ADDR_W = 2;
  localparam int unsigned REG_DATA_W = 8;
  localparam int unsigned SYNC_STAGES = 3;

  // register offsets
  localparam logic [REG_ADDR_W-1:0] CTRL_OFFSET = 2'h0;
  localparam logic [REG_ADDR_W-1:0] CLEAR_OFFSET = 2'h1;
  localparam logic [REG_ADDR_W-1:0] STATUS_OFFSET = 2'h2;

  // control fields
  localparam int unsigned CTRL_SYNC_BIT = 0;
  localparam int unsigned CTRL_SINGLE_BIT = 1;
  localparam int unsigned CTRL_CONFIG_BIT = 2;
  localparam logic [REG_DATA_W-1:0] CTRL_RESET = 8'h00;

  // status fields
  localparam int unsigned STAT_SCLK_BIT = 0;
  localparam int unsigned STAT_SINGLE_BIT = 1;
  localparam int unsigned STAT_RIGHT_BIT = 2;
  localparam int unsigned STAT_WRITE_BIT = 3;
  localparam int unsigned STAT_CLEARED_BIT = 4;

  typedef enum logic {
    LOAD_TRANSPARENT,
    LOAD_CLOCKED
  } load_mode_e;
endpackage : ram_blk_pkg
`default_nettype wire

// *** ram_block.sv ***
// 32x4 ram block: front latches, load selection, data pins and config registers
`timescale 1ns/1ps
`default_nettype none
module ram_block #(
  parameter bit RIGHTMOST = 1'b0
) (
  // clock and reset
  input wire logic core_clk_i,
  input wire logic reset_n_i,
  // sector-column clock of the column left and above
  input wire logic sector_clk_i,
  // write side
  input wire logic [ram_blk_pkg::ADDR_W-1:0] write_addr_i,
  input wire logic write_enable_n_i,
  input wire logic [ram_blk_pkg::DATA_W-1:0] data_in_i,
  // read side
  input wire logic [ram_blk_pkg::ADDR_W-1:0] read_addr_i,
  input wire logic output_enable_n_i,
  output logic [ram_blk_pkg::DATA_W-1:0] data_out_o,
  output logic data_out_oe_o,
  // data pin driven back in single-port use
  output logic [ram_blk_pkg::DATA_W-1:0] data_pin_o,
  output logic data_pin_oe_o,
  // register port
  input wire logic [ram_blk_pkg::REG_ADDR_W-1:0] reg_addr_i,
  input wire logic [ram_blk_pkg::REG_DATA_W-1:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [ram_blk_pkg::REG_DATA_W-1:0] reg_rdata_o
);
  localparam int unsigned AW = ram_blk_pkg::ADDR_W;
  localparam int unsigned DW = ram_blk_pkg::DATA_W;
  localparam int unsigned RW = ram_blk_pkg::REG_DATA_W;

  ram_core_if core ();

  // ---------------- register file
  logic [RW-1:0] ctrl_q;
  logic [RW-1:0] ctrl_d;
  logic [RW-1:0] rdata_q;
  logic [RW-1:0] rdata_d;
  logic wrote_q;
  logic wrote_d;
  logic cleared_q;
  logic cleared_d;
  logic clear_hit;
  logic sclk_lvl_q;

  function automatic logic reg_hit(input logic [ram_blk_pkg::REG_ADDR_W-1:0] a,
                                   input logic [ram_blk_pkg::REG_ADDR_W-1:0] off);
    reg_hit = (a == off);
  endfunction : reg_hit

  logic single_port;
  ram_blk_pkg::load_mode_e load_mode;

  assign single_port = ctrl_q[ram_blk_pkg::CTRL_SINGLE_BIT] | RIGHTMOST;
  assign load_mode = ctrl_q[ram_blk_pkg::CTRL_SYNC_BIT] ? ram_blk_pkg::LOAD_CLOCKED
                                                        : ram_blk_pkg::LOAD_TRANSPARENT;

  // clear byte acts only while configuration is open; value written is ignored
  assign clear_hit = reg_wr_i && reg_hit(reg_addr_i, ram_blk_pkg::CLEAR_OFFSET)
                     && ctrl_q[ram_blk_pkg::CTRL_CONFIG_BIT];

  always_comb begin
    ctrl_d = ctrl_q;
    rdata_d = '0;
    wrote_d = wrote_q;
    cleared_d = cleared_q;
    if (reg_wr_i) begin
      if (reg_hit(reg_addr_i, ram_blk_pkg::CTRL_OFFSET)) begin
        ctrl_d = reg_wdata_i;
      end else if (reg_hit(reg_addr_i, ram_blk_pkg::STATUS_OFFSET)) begin
        wrote_d = 1'b0;
        cleared_d = 1'b0;
      end
    end
    if (core.wr_en) begin
      wrote_d = 1'b1;
    end
    if (clear_hit) begin
      cleared_d = 1'b1;
    end
    if (reg_rd_i) begin
      if (reg_hit(reg_addr_i, ram_blk_pkg::CTRL_OFFSET)) begin
        rdata_d = ctrl_q;
      end else if (reg_hit(reg_addr_i, ram_blk_pkg::STATUS_OFFSET)) begin
        rdata_d[ram_blk_pkg::STAT_SCLK_BIT] = sclk_lvl_q;
        rdata_d[ram_blk_pkg::STAT_SINGLE_BIT] = single_port;
        rdata_d[ram_blk_pkg::STAT_RIGHT_BIT] = RIGHTMOST;
        rdata_d[ram_blk_pkg::STAT_WRITE_BIT] = wrote_q;
        rdata_d[ram_blk_pkg::STAT_CLEARED_BIT] = cleared_q;
      end
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (!reset_n_i) begin
      ctrl_q <= ram_blk_pkg::CTRL_RESET;
      rdata_q <= '0;
      wrote_q <= 1'b0;
      cleared_q <= 1'b0;
    end else begin
      ctrl_q <= ctrl_d;
      rdata_q <= rdata_d;
      wrote_q <= wrote_d;
      cleared_q <= cleared_d;
    end
  end

  assign reg_rdata_o = rdata_q;

  // ---------------- sector clock sampling
  logic [ram_blk_pkg::SYNC_STAGES-1:0] sclk_sync_q;
  logic [ram_blk_pkg::SYNC_STAGES-1:0] sclk_sync_d;
  logic sclk_lvl_d;

  always_comb begin
    sclk_sync_d = {sclk_sync_q[ram_blk_pkg::SYNC_STAGES-2:0], sector_clk_i};
    sclk_lvl_d = sclk_lvl_q;
    if (sclk_sync_q[1] == sclk_sync_q[2]) begin
      sclk_lvl_d = sclk_sync_q[2];
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (!reset_n_i) begin
      sclk_sync_q <= '0;
      sclk_lvl_q <= 1'b0;
    end else begin
      sclk_sync_q <= sclk_sync_d;
      sclk_lvl_q <= sclk_lvl_d;
    end
  end

  // ---------------- load selection
  logic front_load;
  logic store_load;

  // one choice steers both selectors; opposite phases make an edge-triggered write
  always_comb begin
    front_load = 1'b1;
    store_load = 1'b1;
    case (load_mode)
      ram_blk_pkg::LOAD_CLOCKED: begin
        front_load = ~sclk_lvl_q;
        store_load = sclk_lvl_q;
      end
      default: begin
        front_load = 1'b1;
        store_load = 1'b1;
      end
    endcase
  end

  // ---------------- front latches
  logic [AW-1:0] waddr_l;
  logic wen_n_l;
  logic [DW-1:0] wdata_l;

  front_latch #(
    .WIDTH(AW + 1 + DW)
  ) u_front (
    .core_clk_i(core_clk_i),
    .reset_n_i(reset_n_i),
    .load_i(front_load),
    .d_i({write_addr_i, write_enable_n_i, data_in_i}),
    .q_o({waddr_l, wen_n_l, wdata_l})
  );

  // ---------------- storage array
  assign core.wr_en = store_load && !wen_n_l;
  assign core.wr_addr = waddr_l;
  assign core.wr_data = wdata_l;
  assign core.clear = clear_hit;
  // single-port reads at the write address; rightmost read address tied off
  assign core.rd_addr = single_port ? write_addr_i : read_addr_i;

  ram_store #(
    .WORDS(ram_blk_pkg::WORDS)
  ) u_store (
    .core_clk_i(core_clk_i),
    .core(core)
  );

  // ---------------- output drivers
  always_comb begin
    data_out_o = core.rd_data;
    data_pin_o = core.rd_data;
    data_out_oe_o = !output_enable_n_i && !single_port;
    data_pin_oe_o = !output_enable_n_i && single_port;
  end
endmodule : ram_block
`default_nettype wire

// *** ram_block_bench.sv ***
// self-checking bench for the ram block
`timescale 1ns/1ps
`default_nettype none
module ram_block_bench;
  logic core_clk_i = 1'b0;
  logic reset_n_i = 1'b0;
  logic run = 1'b0;
  logic sclk;
  logic [4:0] wa = 5'h00;
  logic [4:0] ra = 5'h00;
  logic we_n = 1'b1;
  logic oe_n = 1'b1;
  logic [3:0] drv = 4'h0;
  logic [3:0] din, dout, pin;
  logic dout_oe, pin_oe;
  logic [1:0] rga = 2'h0;
  logic [7:0] rgd = 8'h00;
  logic rwr = 1'b0;
  logic rrd = 1'b0;
  logic [7:0] rdata;
  logic [3:0] mem [32];
  int errors = 0;
  int check_count = 0;
  int cyc = 0;
  int seed = 9;
  always #25 core_clk_i = !core_clk_i;
  ram_block i_dut (.core_clk_i(core_clk_i), .reset_n_i(reset_n_i), .sector_clk_i(sclk),
    .write_addr_i(wa), .write_enable_n_i(we_n), .data_in_i(din), .read_addr_i(ra),
    .output_enable_n_i(oe_n), .data_out_o(dout), .data_out_oe_o(dout_oe), .data_pin_o(pin),
    .data_pin_oe_o(pin_oe), .reg_addr_i(rga), .reg_wdata_i(rgd), .reg_wr_i(rwr),
    .reg_rd_i(rrd), .reg_rdata_o(rdata));
  fabric_model i_fab (.core_clk_i(core_clk_i), .run_i(run), .sector_clk_o(sclk),
    .pin_out_i(pin), .pin_oe_i(pin_oe), .drive_i(drv), .pin_in_o(din));
  task automatic results();
    $display("errors=%0d checks=%0d", errors, check_count);
    if (errors == 0 && check_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : results
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    rga <= a;
    rgd <= d;
    rwr <= 1'b1;
    @(posedge core_clk_i);
    rwr <= 1'b0;
    @(posedge core_clk_i);
  endtask : wr
  task automatic rd(input logic [1:0] a, input logic [7:0] e);
    rga <= a;
    rrd <= 1'b1;
    @(posedge core_clk_i);
    rrd <= 1'b0;
    @(negedge core_clk_i);
    chk(rdata, e);
    @(posedge core_clk_i);
  endtask : rd
  // write one word while reading the same or another word in the same cycle
  task automatic wrr(input logic [4:0] a, input logic [3:0] d, input logic [4:0] r);
    wa <= a;
    drv <= d;
    ra <= r;
    we_n <= 1'b0;
    @(negedge core_clk_i);
    chk({4'h0, dout}, {4'h0, mem[r]});
    @(posedge core_clk_i);
    mem[a] = d;
  endtask : wrr
  task automatic look(input logic [4:0] r);
    ra <= r;
    @(negedge core_clk_i);
    chk({4'h0, dout}, {4'h0, mem[r]});
    @(posedge core_clk_i);
  endtask : look
  always @(posedge core_clk_i) begin
    cyc++;
    if (cyc == 4000) begin
      errors++;
      results();
    end
  end
  initial begin
    repeat (6) @(posedge core_clk_i);
    reset_n_i <= 1'b1;
    @(posedge core_clk_i);
    rd(2'h3, 8'h00);
    wr(2'h0, 8'h04);
    wr(2'h1, 8'h5A);
    foreach (mem[i]) mem[i] = 4'h0;
    rd(2'h1, 8'h00);
    rd(2'h2, 8'h10);
    oe_n <= 1'b0;
    wrr(5'h1F, 4'hF, 5'h00);
    wrr(5'h00, 4'h9, 5'h1F);
    wrr(5'h05, 4'h6, 5'h05);
    wrr(5'h05, 4'h3, 5'h05);
    for (int i = 0; i < 60; i++) begin
      wrr(5'($random(seed)), 4'($random(seed)), 5'($random(seed)));
    end
    we_n <= 1'b1;
    for (int i = 0; i < 32; i++) look(5'(i));
    oe_n <= 1'b1;
    @(negedge core_clk_i);
    chk({6'h00, dout_oe, pin_oe}, 8'h00);
    @(posedge core_clk_i);
    wr(2'h0, 8'h02);
    wa <= 5'h0A;
    drv <= 4'hC;
    we_n <= 1'b0;
    @(posedge core_clk_i);
    mem[10] = 4'hC;
    we_n <= 1'b1;
    oe_n <= 1'b0;
    ra <= 5'h0B;
    @(negedge core_clk_i);
    chk({3'h0, pin_oe, pin}, 8'h1C);
    chk({3'h0, dout_oe, din}, 8'h0C);
    @(posedge core_clk_i);
    wr(2'h0, 8'h01);
    wa <= 5'h03;
    ra <= 5'h03;
    drv <= ~mem[3];
    we_n <= 1'b0;
    repeat (12) @(posedge core_clk_i);
    look(5'h03);
    run <= 1'b1;
    repeat (30) @(posedge core_clk_i);
    we_n <= 1'b1;
    repeat (24) @(posedge core_clk_i);
    run <= 1'b0;
    mem[3] = ~mem[3];
    repeat (12) @(posedge core_clk_i);
    look(5'h03);
    wr(2'h0, 8'h00);
    wr(2'h1, 8'hFF);
    look(5'h0A);
    wr(2'h0, 8'h04);
    wr(2'h1, 8'h00);
    foreach (mem[i]) mem[i] = 4'h0;
    look(5'h0A);
    rd(2'h0, 8'h04);
    rd(2'h2, 8'h18);
    wr(2'h2, 8'h00);
    rd(2'h2, 8'h00);
    results();
  end
endmodule : ram_block_bench
`default_nettype wire

// *** ram_block_sva.sv ***
// port assertions for the ram block
`timescale 1ns/1ps
`default_nettype none
module ram_block_sva (
  // clock and reset
  input wire logic core_clk_i,
  input wire logic reset_n_i,
  // ram side
  input wire logic [4:0] write_addr_i,
  input wire logic write_enable_n_i,
  input wire logic [3:0] data_in_i,
  input wire logic [4:0] read_addr_i,
  input wire logic output_enable_n_i,
  input wire logic [3:0] data_out_o,
  input wire logic data_out_oe_o,
  input wire logic [3:0] data_pin_o,
  input wire logic data_pin_oe_o,
  // register port
  input wire logic [1:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [7:0] reg_rdata_o
);
  logic [2:0] mode_q;
  always_ff @(posedge core_clk_i) begin
    if (!reset_n_i) begin
      mode_q <= 3'h0;
    end else if (reg_wr_i && reg_addr_i == 2'h0) begin
      mode_q <= reg_wdata_i[2:0];
    end
  end
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!reset_n_i);
  a_oe_off: assert property (output_enable_n_i |-> !data_out_oe_o && !data_pin_oe_o)
    else $error("driven while disabled");
  a_dual_out: assert property (!mode_q[1] && !output_enable_n_i |-> data_out_oe_o && !data_pin_oe_o)
    else $error("dual enable wrong");
  a_single_pin: assert property (mode_q[1] && !output_enable_n_i |-> data_pin_oe_o && !data_out_oe_o)
    else $error("single enable wrong");
  a_clear_read: assert property (reg_rd_i && reg_addr_i == 2'h1 |=> reg_rdata_o == 8'h00)
    else $error("clear byte read");
  a_clear_zero: assert property (mode_q[2] && reg_wr_i && reg_addr_i == 2'h1 |=> data_out_o == 4'h0 && data_pin_o == 4'h0)
    else $error("clear missed");
  a_async_write: assert property (mode_q[1:0] == 2'h0 && !write_enable_n_i && !reg_wr_i && read_addr_i == write_addr_i ##1 $stable(read_addr_i) |-> data_out_o == $past(data_in_i))
    else $error("write not seen");
  a_single_read: assert property (mode_q[1:0] == 2'h2 && !write_enable_n_i && !reg_wr_i ##1 $stable(write_addr_i) |-> data_pin_o == $past(data_in_i))
    else $error("single read wrong");
  a_read_stable: assert property (!mode_q[0] && write_enable_n_i && !reg_wr_i ##1 $stable(read_addr_i) && $stable(write_addr_i) |-> $stable(data_out_o))
    else $error("read moved");
endmodule : ram_block_sva
bind ram_block ram_block_sva i_sva (
  .core_clk_i(core_clk_i),
  .reset_n_i(reset_n_i),
  .write_addr_i(write_addr_i),
  .write_enable_n_i(write_enable_n_i),
  .data_in_i(data_in_i),
  .read_addr_i(read_addr_i),
  .output_enable_n_i(output_enable_n_i),
  .data_out_o(data_out_o),
  .data_out_oe_o(data_out_oe_o),
  .data_pin_o(data_pin_o),
  .data_pin_oe_o(data_pin_oe_o),
  .reg_addr_i(reg_addr_i),
  .reg_wdata_i(reg_wdata_i),
  .reg_wr_i(reg_wr_i),
  .reg_rd_i(reg_rd_i),
  .reg_rdata_o(reg_rdata_o)
);
`default_nettype wire

// *** ram_core_if.sv ***
// write and read signals between the ram control and the storage array
`timescale 1ns/1ps
`default_nettype none
interface ram_core_if;
  logic wr_en;
  logic [ram_blk_pkg::ADDR_W-1:0] wr_addr;
  logic [ram_blk_pkg::DATA_W-1:0] wr_data;
  logic clear;
  logic [ram_blk_pkg::ADDR_W-1:0] rd_addr;
  logic [ram_blk_pkg::DATA_W-1:0] rd_data;

  modport ctrl (
    output wr_en,
    output wr_addr,
    output wr_data,
    output clear,
    output rd_addr,
    input rd_data
  );

  modport store (
    input wr_en,
    input wr_addr,
    input wr_data,
    input clear,
    input rd_addr,
    output rd_data
  );
endinterface : ram_core_if
`default_nettype wire

// *** ram_store.sv ***
// 32x4 storage array with clear and combinational read
`timescale 1ns/1ps
`default_nettype none
module ram_store #(
  parameter int unsigned WORDS = ram_blk_pkg::WORDS
) (
  // clock
  input wire logic core_clk_i,
  // array access
  ram_core_if.store core
);
  logic [ram_blk_pkg::DATA_W-1:0] mem_q [WORDS];
  logic [ram_blk_pkg::DATA_W-1:0] mem_d [WORDS];

  genvar gi;
  generate
    for (gi = 0; gi < WORDS; gi++) begin : g_word
      always_comb begin
        mem_d[gi] = mem_q[gi];
        if (core.clear) begin
          mem_d[gi] = '0;
        end else if (core.wr_en && (core.wr_addr == ram_blk_pkg::ADDR_W'(gi))) begin
          mem_d[gi] = core.wr_data;
        end
      end

      always_ff @(posedge core_clk_i) begin
        mem_q[gi] <= mem_d[gi];
      end
    end
  endgenerate

  // read does not wait for any clock
  assign core.rd_data = mem_q[core.rd_addr];
endmodule : ram_store
`default_nettype wire
